// ### rtl/imrc_consts.svh
// Constants for the mode and rate control block: offsets, fields, resets, rates.
// Assumes inclusion by bare name from the package and the top file.
`ifndef IMRC_CONSTS_SVH
`define IMRC_CONSTS_SVH

// Register byte addresses
`define IMRC_OFS_CTL 8'h00
`define IMRC_OFS_SADDR 8'h04
`define IMRC_OFS_RXBUF 8'h08
`define IMRC_OFS_STAT 8'h0C

// Field positions in the control register
`define IMRC_BIT_ENABLE 7
`define IMRC_BIT_INHIBIT 6
`define IMRC_BIT_MASTER 5
`define IMRC_BIT_TRANSMIT 4

// Reset values
`define IMRC_CTL_RESET 8'h00
`define IMRC_SADDR_RESET 7'h00

// Receive FIFO shape
`define IMRC_FIFO_WIDTH 8
`define IMRC_FIFO_DEPTH 4

// System clocks per serial clock period, entry n at bits [9n+8:9n]
`define IMRC_DIV_TABLE {9'h100, 9'h0E0, 9'h0C8, 9'h0A0, 9'h080, 9'h060, 9'h050, 9'h038, \
   9'h080, 9'h070, 9'h064, 9'h050, 9'h040, 9'h030, 9'h028, 9'h01C}

`endif

// ### rtl/imrc_pkg.sv
// Types for the mode and rate control block.
// Assumes the constants header sits beside it.
`include "imrc_consts.svh"

package imrc_pkg;

   // Control register image
   typedef struct packed {
      logic enable;
      logic inhibit;
      logic master;
      logic transmit;
      logic [3:0] divsel;
   } imrc_ctl_t;

   // Operating mode as the master and transmit pair
   typedef enum logic [1:0] {
      IMRC_SLAVE_RX,
      IMRC_SLAVE_TX,
      IMRC_MASTER_RX,
      IMRC_MASTER_TX
   } imrc_mode_t;

endpackage

// ### rtl/imrc_top.sv
// Mode and rate control of a two-wire serial interface, with its receive FIFO.
// Assumes an APB master on the same clock and shift logic that feeds bytes and
// event pulses on this clock; the serial pins come from outside and are synchronised.
`timescale 1ns/1ps
`include "imrc_consts.svh"

module imrc_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   // Fill level
   output logic [$clog2(DEPTH):0] level
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_reg;
   logic [AW-1:0] rd_ptr_reg;
   logic [AW:0] count_reg;
   logic [AW:0] count_next;
   logic ready_reg;
   logic empty_reg;
   wire push = in_valid & ready_reg;
   wire pop = out_ready & ~empty_reg;

   // Level after this cycle's push and pop
   assign count_next = count_reg + (AW + 1)'(push) - (AW + 1)'(pop);
   assign in_ready = ready_reg;
   assign out_valid = ~empty_reg;
   assign out_data = mem[rd_ptr_reg];
   assign level = count_reg;

   // Storage write
   always_ff @(posedge clock) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_data;
      end
   end

   // Pointers and flags
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
         ready_reg <= 1'b1;
         empty_reg <= 1'b1;
      end else begin
         wr_ptr_reg <= push ? AW'((wr_ptr_reg + 1'b1) % DEPTH) : wr_ptr_reg;
         rd_ptr_reg <= pop ? AW'((rd_ptr_reg + 1'b1) % DEPTH) : rd_ptr_reg;
         count_reg <= count_next;
         ready_reg <= (count_next != (AW + 1)'(DEPTH));
         empty_reg <= (count_next == '0);
      end
   end
endmodule

module imrc_top (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // To and from the shift and condition logic
   input wire logic sync_format,
   input wire logic arb_lost,
   input wire logic addr_phase,
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   output logic rx_ready,
   input wire logic sda_tx_en,
   input wire logic sda_tx_bit,
   // Control toward the shift logic
   output logic rx_next_start,
   output logic [1:0] op_mode,
   output logic bus_drive,
   // Serial pins
   input wire logic scl_in,
   input wire logic sda_in,
   output logic scl_out,
   output logic scl_oe,
   output logic sda_out,
   output logic sda_oe,
   output logic scl_sense,
   output logic sda_sense
);
   localparam logic [143:0] DIV_TABLE = `IMRC_DIV_TABLE;
   imrc_pkg::imrc_ctl_t ctl_reg;
   imrc_pkg::imrc_ctl_t ctl_next;
   logic [6:0] saddr_reg;
   logic [31:0] prdata_reg;
   logic pready_reg;
   logic pslverr_reg;
   logic rx_start_reg;
   logic [1:0] pin_meta_reg;
   logic [1:0] pin_sync_reg;
   logic [7:0] half_cnt_reg;
   logic scl_level_reg;
   logic [3:0] divsel_seen_reg;
   logic scl_out_reg;
   logic scl_oe_reg;
   logic sda_out_reg;
   logic sda_oe_reg;
   logic [7:0] fifo_data;
   logic fifo_valid;
   logic fifo_in_ready;
   logic [2:0] fifo_level;

   // Bus decode
   wire setup_acc = psel & penable & ~pready_reg;
   wire done_acc = psel & penable & pready_reg;
   wire hit_ctl = (paddr == `IMRC_OFS_CTL);
   wire hit_saddr = (paddr == `IMRC_OFS_SADDR);
   wire hit_rxbuf = (paddr == `IMRC_OFS_RXBUF);
   wire hit_stat = (paddr == `IMRC_OFS_STAT);
   wire hit_any = hit_ctl | hit_saddr | hit_rxbuf | hit_stat;
   wire wr_ctl = done_acc & pwrite & hit_ctl;
   wire wr_saddr = done_acc & pwrite & hit_saddr;
   wire rd_rxbuf = done_acc & ~pwrite & hit_rxbuf;

   // Mode decode and events
   wire [1:0] mode_bits = {ctl_reg.master, ctl_reg.transmit};
   wire is_slave_rx = ctl_reg.enable & (mode_bits == 2'(imrc_pkg::IMRC_SLAVE_RX));
   wire lose_arb = ctl_reg.enable & ~sync_format & ctl_reg.master & arb_lost;
   wire overrun = ctl_reg.enable & sync_format & ctl_reg.master
      & rx_valid & ~fifo_in_ready;
   wire addr_match = is_slave_rx & addr_phase & rx_valid
      & (rx_data[7:1] == saddr_reg) & rx_data[0];
   wire restart_rx = rd_rxbuf & ~ctl_reg.transmit & ~ctl_reg.inhibit;

   // Rate generator selection
   wire [8:0] div_full = DIV_TABLE[9*ctl_reg.divsel +: 9];
   wire [7:0] div_half = div_full[8:1];
   wire rate_run = ctl_reg.enable & ctl_reg.master;
   wire div_changed = (divsel_seen_reg != ctl_reg.divsel);
   wire half_done = (half_cnt_reg == div_half - 8'h01);
   wire [7:0] stat_word = {fifo_level, fifo_valid, sync_format, mode_bits, ctl_reg.enable};

   // Control next value: hardware set beats software, clears beat writes
   always_comb begin
      ctl_next = ctl_reg;
      if (wr_ctl) begin
         ctl_next = imrc_pkg::imrc_ctl_t'(pwdata[7:0]);
      end
      if (lose_arb) begin
         ctl_next.master = 1'b0;
         ctl_next.transmit = 1'b0;
      end
      if (overrun) begin
         ctl_next.master = 1'b0;
      end
      if (addr_match) begin
         ctl_next.transmit = 1'b1;
      end
   end

   // Register file and APB answer with one wait state
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ctl_reg <= imrc_pkg::imrc_ctl_t'(`IMRC_CTL_RESET);
         saddr_reg <= `IMRC_SADDR_RESET;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
         rx_start_reg <= 1'b0;
      end else begin
         ctl_reg <= ctl_next;
         saddr_reg <= wr_saddr ? pwdata[7:1] : saddr_reg;
         pready_reg <= setup_acc;
         pslverr_reg <= setup_acc & ~hit_any;
         prdata_reg <= 32'h0000_0000;
         if (setup_acc & ~pwrite) begin
            prdata_reg <= hit_ctl ? {24'h00_0000, ctl_reg} :
               hit_saddr ? {24'h00_0000, saddr_reg, 1'b0} :
               hit_rxbuf ? {24'h00_0000, fifo_data} :
               hit_stat ? {24'h00_0000, stat_word} : 32'h0000_0000;
         end
         rx_start_reg <= restart_rx;
      end
   end

   // Pin synchronisers, two stages each
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pin_meta_reg <= 2'b11;
         pin_sync_reg <= 2'b11;
      end else begin
         pin_meta_reg <= {scl_in, sda_in};
         pin_sync_reg <= pin_meta_reg;
      end
   end

   // Serial clock generator: half period counter restarted on divisor change
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         half_cnt_reg <= 8'h00;
         scl_level_reg <= 1'b1;
         divsel_seen_reg <= 4'h0;
      end else begin
         divsel_seen_reg <= ctl_reg.divsel;
         if (!rate_run || div_changed) begin
            half_cnt_reg <= 8'h00;
            scl_level_reg <= 1'b1;
         end else if (half_done) begin
            half_cnt_reg <= 8'h00;
            scl_level_reg <= ~scl_level_reg;
         end else begin
            half_cnt_reg <= half_cnt_reg + 8'h01;
         end
      end
   end

   // Pin drivers: released when disabled, open drain low or push-pull otherwise
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         scl_out_reg <= 1'b0;
         scl_oe_reg <= 1'b0;
         sda_out_reg <= 1'b0;
         sda_oe_reg <= 1'b0;
      end else begin
         scl_out_reg <= sync_format & scl_level_reg;
         scl_oe_reg <= rate_run & (sync_format | ~scl_level_reg);
         sda_out_reg <= sync_format & sda_tx_bit;
         sda_oe_reg <= ctl_reg.enable & sda_tx_en
            & (sync_format | ~sda_tx_bit);
      end
   end

   // Receive FIFO between shifter and data buffer
   imrc_fifo #(
      .WIDTH(`IMRC_FIFO_WIDTH),
      .DEPTH(`IMRC_FIFO_DEPTH)
   ) u_rx_fifo (
      .clock(clock),
      .rst_n(rst_n),
      .in_valid(rx_valid & ctl_reg.enable),
      .in_ready(fifo_in_ready),
      .in_data(rx_data),
      .out_valid(fifo_valid),
      .out_ready(rd_rxbuf),
      .out_data(fifo_data),
      .level(fifo_level)
   );

   // Outputs
   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign rx_ready = fifo_in_ready;
   assign rx_next_start = rx_start_reg;
   assign op_mode = ctl_reg[5:4];
   assign bus_drive = ctl_reg.enable;
   assign scl_out = scl_out_reg;
   assign scl_oe = scl_oe_reg;
   assign sda_out = sda_out_reg;
   assign sda_oe = sda_oe_reg;
   assign scl_sense = pin_sync_reg[1];
   assign sda_sense = pin_sync_reg[0];

   // Checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   property p_off_released;
      !ctl_reg.enable [*2] |-> !scl_oe && !sda_oe;
   endproperty
   a_off_released: assert property (p_off_released) else $error("pins driven while off");

   property p_on_drive;
      rate_run && sync_format && $stable(sync_format) |=> scl_oe;
   endproperty
   a_on_drive: assert property (p_on_drive) else $error("master clock not driven");

   property p_restart;
      rd_rxbuf |=> (rx_next_start == (!$past(ctl_reg.inhibit) && !$past(ctl_reg.transmit)));
   endproperty
   a_restart: assert property (p_restart) else $error("reception restart wrong");

   property p_mode;
      wr_ctl && !lose_arb && !overrun && !addr_match |=> op_mode == $past(pwdata[5:4]);
   endproperty
   a_mode: assert property (p_mode) else $error("mode pair mismatch");

   property p_arb;
      lose_arb && !addr_match |=> !ctl_reg.master && !ctl_reg.transmit;
   endproperty
   a_arb: assert property (p_arb) else $error("arbitration loss kept master");

   property p_match;
      addr_match |=> ctl_reg.transmit;
   endproperty
   a_match: assert property (p_match) else $error("address match missed");

   property p_overrun;
      overrun |=> !ctl_reg.master;
   endproperty
   a_overrun: assert property (p_overrun) else $error("overrun kept master");

   property p_slave_idle;
      !rate_run |=> half_cnt_reg == 8'h00 && scl_level_reg;
   endproperty
   a_slave_idle: assert property (p_slave_idle) else $error("rate runs in slave");

   property p_half;
      rate_run && !div_changed && half_done |=> $changed(scl_level_reg) || !rate_run;
   endproperty
   a_half: assert property (p_half) else $error("half period not ended");

   property p_period_28;
      rate_run && ctl_reg.divsel == 4'h0 && $rose(scl_level_reg) && !div_changed
         |-> ##14 (!scl_level_reg || !rate_run || ctl_reg.divsel != 4'h0);
   endproperty
   a_period_28: assert property (p_period_28) else $error("divide by 28 wrong");

   c_arb: cover property (lose_arb);
   c_match: cover property (addr_match);
   c_overrun: cover property (overrun);
   c_restart: cover property (rx_next_start);
endmodule

// ### dv/imrc_bus_peer.sv
// Model of the two-wire bus beyond the block: pull-up lines and one other device.
// Assumes the block's pin drivers, with output enable high while driving.
`timescale 1ns/1ps

module imrc_bus_peer (
   // Pin drivers from the block
   input wire logic scl_out,
   input wire logic scl_oe,
   input wire logic sda_out,
   input wire logic sda_oe,
   // Other device holds data low
   input wire logic peer_sda_low,
   // Resolved line levels
   output logic scl_line,
   output logic sda_line
);
   // Lines rest high through the pull-up; any driver of a low wins
   assign scl_line = ~(scl_oe & ~scl_out);
   assign sda_line = ~((sda_oe & ~sda_out) | peer_sda_low);
endmodule

// ### dv/tb_imrc_top.sv
// Self-checking testbench of the mode and rate control block.
// Assumes the design files and the bus peer model are compiled before it.
`timescale 1ns/1ps

module tb_imrc_top;
   typedef struct packed {
      logic [7:0] ctl;
      logic [8:0] per;
   } imrc_row_t;
   logic clock, rst_n, psel, penable, pwrite, pready, pslverr, er, sprev;
   logic sync_format, arb_lost, addr_phase, rx_valid, rx_ready, rx_next_start, bus_drive;
   logic scl_in, sda_in, scl_out, scl_oe, sda_out, sda_oe, scl_sense, sda_sense;
   logic sda_tx_en = 1'b0, sda_tx_bit = 1'b0, peer_sda_low = 1'b0;
   logic [7:0] paddr, rx_data;
   logic [1:0] op_mode;
   logic [31:0] pwdata, prdata, rd, snap, cnt = 0, last_per = 0, rises = 0, starts = 0;
   int num_errors = 0, check_count = 0;
   // Divisor code in master synchronous mode beside its period
   imrc_row_t rows [16] = '{'{8'hA0, 9'h01C}, '{8'hA1, 9'h028}, '{8'hA2, 9'h030},
      '{8'hA3, 9'h040}, '{8'hA4, 9'h050}, '{8'hA5, 9'h064}, '{8'hA6, 9'h070},
      '{8'hA7, 9'h080}, '{8'hA8, 9'h038}, '{8'hA9, 9'h050}, '{8'hAA, 9'h060},
      '{8'hAB, 9'h080}, '{8'hAC, 9'h0A0}, '{8'hAD, 9'h0C8}, '{8'hAE, 9'h0E0},
      '{8'hAF, 9'h100}};

   imrc_top i_dut (.clock, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .sync_format, .arb_lost, .addr_phase, .rx_valid, .rx_data,
      .rx_ready, .sda_tx_en, .sda_tx_bit, .rx_next_start, .op_mode, .bus_drive, .scl_in,
      .sda_in, .scl_out, .scl_oe, .sda_out, .sda_oe, .scl_sense, .sda_sense);
   imrc_bus_peer i_peer (.scl_out, .scl_oe, .sda_out, .sda_oe, .peer_sda_low,
      .scl_line(scl_in), .sda_line(sda_in));

   // Clock at 4 ns
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   // Serial clock period, rising edges and restart pulses
   always @(posedge clock) begin
      sprev <= scl_out;
      cnt <= cnt + 1;
      if (scl_out === 1'b1 && sprev === 1'b0) begin
         last_per <= cnt;
         cnt <= 1;
         rises <= rises + 1;
      end
      if (rx_next_start === 1'b1) starts <= starts + 1;
   end

   task give_verdict;
      $display("errors %0d checks %0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   task chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         num_errors++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask

   // One APB transfer; waits for the answer, the watchdog bounds it
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // One received byte from the shifter
   task rx_byte(input logic [7:0] d, input logic ap);
      @(posedge clock);
      rx_valid <= 1'b1;
      rx_data <= d;
      addr_phase <= ap;
      @(posedge clock);
      rx_valid <= 1'b0;
      addr_phase <= 1'b0;
      repeat (2) @(posedge clock);
   endtask

   // Control value under which no serial clock may run
   task quiet(input logic [7:0] c, input logic bd);
      apb(1'b1, 8'h00, {24'h00_0000, c});
      repeat (300) @(posedge clock);
      snap = rises;
      repeat (300) @(posedge clock);
      chk(rises, snap);
      chk(scl_oe, 1'b0);
      chk(bus_drive, bd);
   endtask

   // Hang guard
   initial begin
      repeat (40000) @(posedge clock);
      num_errors++;
      give_verdict;
   end

   // Main sequence
   initial begin
      rst_n = 1'b0;
      {psel, penable, pwrite, arb_lost, addr_phase, rx_valid} = '0;
      {paddr, rx_data, pwdata} = '0;
      sync_format = 1'b1;
      repeat (16) @(posedge clock);
      rst_n <= 1'b1;
      apb(1'b0, 8'h00, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      chk(op_mode, 2'b00);
      chk(scl_oe, 1'b0);
      foreach (rows[i]) begin
         apb(1'b1, 8'h00, {24'h00_0000, rows[i].ctl});
         repeat (600) @(posedge clock);
         chk(last_per, {23'h00_0000, rows[i].per});
      end
      // Mode writes only while no frame runs
      for (int m = 0; m < 4; m++) begin
         apb(1'b1, 8'h00, 32'h0000_0080 | (m << 4));
         repeat (2) @(posedge clock);
         chk(op_mode, m[1:0]);
         chk(bus_drive, 1'b1);
      end
      quiet(8'h20, 1'b0);
      quiet(8'h83, 1'b1);
      sync_format <= 1'b0;
      apb(1'b1, 8'h00, 32'h0000_00B0);
      @(posedge clock);
      arb_lost <= 1'b1;
      @(posedge clock);
      arb_lost <= 1'b0;
      repeat (2) @(posedge clock);
      chk(op_mode, 2'b00);
      sync_format <= 1'b1;
      apb(1'b1, 8'h00, 32'h0000_00A0);
      for (int k = 0; k < 5; k++) rx_byte(8'(8'h11 + k), 1'b0);
      chk(rx_ready, 1'b0);
      chk(op_mode, 2'b00);
      for (int k = 0; k < 4; k++) begin
         apb(1'b0, 8'h08, 32'h0000_0000);
         chk(rd, 32'h0000_0011 + k);
      end
      // Let the last restart pulse reach the count first
      repeat (2) @(posedge clock);
      snap = starts;
      apb(1'b0, 8'h08, 32'h0000_0000);
      repeat (2) @(posedge clock);
      chk(starts, snap + 1);
      apb(1'b1, 8'h00, 32'h0000_00C0);
      apb(1'b0, 8'h08, 32'h0000_0000);
      repeat (2) @(posedge clock);
      chk(starts, snap + 1);
      sync_format <= 1'b0;
      apb(1'b1, 8'h04, 32'h0000_00A4);
      apb(1'b1, 8'h00, 32'h0000_0080);
      rx_byte(8'hA4, 1'b1);
      chk(op_mode, 2'b00);
      rx_byte(8'hA5, 1'b1);
      chk(op_mode, 2'b01);
      // Data pin drive and sense, then a reset in mid-run
      sda_tx_en <= 1'b1;
      repeat (4) @(posedge clock);
      chk(sda_oe, 1'b1);
      chk(sda_out, 1'b0);
      chk(sda_sense, 1'b0);
      rst_n <= 1'b0;
      repeat (2) @(posedge clock);
      chk(op_mode, 2'b00);
      chk(bus_drive, 1'b0);
      chk(sda_oe, 1'b0);
      chk(sda_sense, 1'b1);
      chk(rx_ready, 1'b1);
      rst_n <= 1'b1;
      repeat (4) @(posedge clock);
      chk(sda_oe, 1'b0);
      chk(scl_sense, 1'b1);
      peer_sda_low <= 1'b1;
      repeat (4) @(posedge clock);
      chk(sda_sense, 1'b0);
      apb(1'b0, 8'h10, 32'h0000_0000);
      chk(er, 1'b1);
      chk(rd, 32'h0000_0000);
      give_verdict;
   end
endmodule
